// >>> wtvs_pkg.sv
package wtvs_pkg;

  // Channel layout: index 2*e is the voltage of element e, 2*e+1 its current.
  localparam int NUM_ELEM = 4;
  localparam int NUM_CH = 8;
  localparam int SAMPLE_W = 16;
  localparam int LEVEL_W = 11;
  localparam int POS_W = 18;
  localparam int ZOOM_W = 5;
  localparam int ZOOM_Q_W = 15;
  localparam int ZOOM_FRAC = 8;
  localparam int TIMER_W = 17;
  localparam int DIV_W = 5;

  // Sample code that stands for 100 % of full scale (range times crest factor).
  localparam int FULL_SCALE_CODE = 16000;
  localparam int LEVEL_PER_FULL = 1000;
  localparam logic signed [LEVEL_W-1:0] LEVEL_LIMIT = 11'sh3e8;
  localparam int POS_PER_FULL = 100000;
  localparam logic signed [POS_W-1:0] POS_LIMIT = 18'sh1fbd0;
  localparam int SAMPLE_MAX = 32767;
  localparam int SAMPLE_MIN = -32768;

  // Hysteresis in tenths of a percent for crest factor 3 and 6.
  localparam int HYST_CF3_PERMILLE = 20;
  localparam int HYST_CF6_PERMILLE = 40;
  localparam int HYST_CF3_CODE = FULL_SCALE_CODE * HYST_CF3_PERMILLE / LEVEL_PER_FULL;
  localparam int HYST_CF6_CODE = FULL_SCALE_CODE * HYST_CF6_PERMILLE / LEVEL_PER_FULL;

  // Timing: the auto timeout is counted in microseconds from a divider tick.
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int US_TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int AUTO_TIMEOUT_MS = 100;
  localparam int AUTO_TIMEOUT_US = AUTO_TIMEOUT_MS * 1000;

  localparam logic [3:0] SRC_EXT = 4'h8;

  typedef enum logic {MODE_AUTO = 1'b0, MODE_NORMAL = 1'b1} wtvs_mode_t;
  typedef enum logic [1:0] {SLOPE_RISE = 2'h0, SLOPE_FALL = 2'h1, SLOPE_BOTH = 2'h2} wtvs_slope_t;
  typedef enum logic [1:0] {
    CAUSE_NONE = 2'h0,
    CAUSE_TRIG = 2'h1,
    CAUSE_TIMEOUT = 2'h2,
    CAUSE_FREE = 2'h3
  } wtvs_cause_t;

  typedef struct packed {
    wtvs_mode_t mode;
    wtvs_slope_t slope;
    logic [3:0] source;
    logic signed [LEVEL_W-1:0] level;
    logic crestSix;
  } wtvs_trig_cfg_t;

  typedef struct packed {
    logic [NUM_CH-1:0][SAMPLE_W-1:0] ch;
  } wtvs_samples_t;

  typedef struct packed {
    logic [NUM_CH-1:0][ZOOM_W-1:0] zoomSel;
    logic [NUM_CH-1:0][POS_W-1:0] position;
  } wtvs_vert_cfg_t;

  // Zoom factors as unsigned fixed point with eight fraction bits.
  function automatic logic [ZOOM_Q_W-1:0] wtvs_zoom_q(input logic [ZOOM_W-1:0] idx);
    case (idx)
      5'h00: wtvs_zoom_q = 15'h001a;
      5'h01: wtvs_zoom_q = 15'h0033;
      5'h02: wtvs_zoom_q = 15'h0040;
      5'h03: wtvs_zoom_q = 15'h0066;
      5'h04: wtvs_zoom_q = 15'h0080;
      5'h05: wtvs_zoom_q = 15'h00c0;
      5'h06: wtvs_zoom_q = 15'h00cd;
      5'h07: wtvs_zoom_q = 15'h0100;
      5'h08: wtvs_zoom_q = 15'h0124;
      5'h09: wtvs_zoom_q = 15'h0140;
      5'h0a: wtvs_zoom_q = 15'h0154;
      5'h0b: wtvs_zoom_q = 15'h0169;
      5'h0c: wtvs_zoom_q = 15'h0180;
      5'h0d: wtvs_zoom_q = 15'h019a;
      5'h0e: wtvs_zoom_q = 15'h01c5;
      5'h0f: wtvs_zoom_q = 15'h0200;
      5'h10: wtvs_zoom_q = 15'h0248;
      5'h11: wtvs_zoom_q = 15'h02a9;
      5'h12: wtvs_zoom_q = 15'h02d4;
      5'h13: wtvs_zoom_q = 15'h0333;
      5'h14: wtvs_zoom_q = 15'h038a;
      5'h15: wtvs_zoom_q = 15'h0400;
      5'h16: wtvs_zoom_q = 15'h0500;
      5'h17: wtvs_zoom_q = 15'h0800;
      5'h18: wtvs_zoom_q = 15'h0a00;
      5'h19: wtvs_zoom_q = 15'h0c80;
      5'h1a: wtvs_zoom_q = 15'h1000;
      5'h1b: wtvs_zoom_q = 15'h1400;
      5'h1c: wtvs_zoom_q = 15'h1900;
      5'h1d: wtvs_zoom_q = 15'h2800;
      5'h1e: wtvs_zoom_q = 15'h3200;
      default: wtvs_zoom_q = 15'h6400;
    endcase
  endfunction

endpackage

// >>> wtvs_vscale.sv
`timescale 1ns/1ps
module wtvs_vscale
  import wtvs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire wtvs_samples_t samples,
  input wire logic sampleValid,
  input wire wtvs_vert_cfg_t vertCfg,
  output wtvs_samples_t dispSamples,
  output logic dispValid
);

  typedef struct packed {
    wtvs_samples_t disp;
    logic valid;
  } wtvs_vs_state_t;

  wtvs_vs_state_t s;
  wtvs_vs_state_t next_s;
  logic [NUM_CH-1:0][SAMPLE_W-1:0] scaled;

  // Each waveform keeps its own zoom and position; offset first, then zoom.
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic signed [POS_W-1:0] posClamped;
      int offsetCode;
      longint product;
      always_comb begin
        posClamped = $signed(vertCfg.position[c]);
        // Out-of-range positions are held at the limit rather than wrapped.
        if (posClamped > POS_LIMIT) begin
          posClamped = POS_LIMIT;
        end else if (posClamped < -POS_LIMIT) begin
          posClamped = -POS_LIMIT;
        end
        // Position is a fraction of full scale at zoom 1; zoom scales it too.
        offsetCode = int'(posClamped) * FULL_SCALE_CODE / POS_PER_FULL;
        product = longint'(int'($signed(samples.ch[c])) + offsetCode)
          * longint'(wtvs_zoom_q(vertCfg.zoomSel[c]));
        product = product >>> ZOOM_FRAC;
        // Saturation keeps a zoomed trace pinned to the rails instead of folding.
        if (product > longint'(SAMPLE_MAX)) begin
          scaled[c] = 16'h7fff;
        end else if (product < longint'(SAMPLE_MIN)) begin
          scaled[c] = 16'h8000;
        end else begin
          scaled[c] = product[SAMPLE_W-1:0];
        end
      end
    end
  endgenerate

  // Display words update only with a fresh sample.
  always_comb begin
    next_s = s;
    next_s.valid = sampleValid;
    if (sampleValid) begin
      next_s.disp.ch = scaled;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dispSamples = s.disp;
  assign dispValid = s.valid;

endmodule // wtvs_vscale

// >>> wtvs_trigger.sv
`timescale 1ns/1ps
module wtvs_trigger
  import wtvs_pkg::*;
#(
  parameter int AUTO_TIMEOUT = AUTO_TIMEOUT_US
)(
  input wire logic ref_clk,
  input wire logic reset,
  input wire wtvs_trig_cfg_t trigCfg,
  input wire logic [NUM_ELEM-1:0] elemInstalled,
  input wire wtvs_samples_t samples,
  input wire logic sampleValid,
  input wire logic extTrigIn,
  input wire logic integActive,
  input wire logic updateTick,
  input wire wtvs_vert_cfg_t vertCfg,
  output logic trigPulse,
  output logic refresh,
  output wtvs_cause_t refreshCause,
  output logic sourceValid,
  output wtvs_samples_t dispSamples,
  output logic dispValid
);

  // The sequencer has two states only. In the seek state the comparator
  // watches the selected source and the auto timer runs. In the free state
  // triggering is switched off and the update interval paces the refreshes.
  // One-hot codes keep the decode to a single bit per state.
  // An illegal code falls back to seek, so a glitch costs at most one cycle.
  // No trigger is accepted in the cycle that leaves the free state.
  // That loss is accepted because integration ends far from any trigger.
  typedef enum logic [1:0] {
    ST_SEEK = 2'b01,
    ST_FREE = 2'b10
  } wtvs_state_t;

  // Every bit of state lives in this one struct.
  // The previous sample and its valid bit feed the two-sample crossing test.
  // The two arm bits hold the hysteresis memory for each direction.
  // The last source is kept so that a change of source can be seen.
  // The divider and the microsecond counter form the auto timeout.
  // The output pulses and the cause are registered here as well.
  // Registering them keeps every output of the block straight from a flop.
  typedef struct packed {
    wtvs_state_t fsm;
    logic signed [SAMPLE_W-1:0] prevSample;
    logic prevValid;
    logic armRise;
    logic armFall;
    logic extPrev;
    logic [3:0] lastSource;
    logic [DIV_W-1:0] usDiv;
    logic [TIMER_W-1:0] timeoutUs;
    logic trigPulse;
    logic refresh;
    wtvs_cause_t cause;
    logic sourceValid;
  } wtvs_main_state_t;

  // Terminal counts for the divider and the timeout counter.
  // The timeout is a parameter so that a simulation can use a short one.
  // The divider phase is not tied to any refresh, so the timeout varies
  // by up to one microsecond, which is well inside the loose figure wanted.
  localparam logic [DIV_W-1:0] US_DIV_LAST = DIV_W'(US_TICK_CYCLES - 1);
  localparam logic [TIMER_W-1:0] TIMEOUT_LAST = TIMER_W'(AUTO_TIMEOUT - 1);

  wtvs_main_state_t s;
  wtvs_main_state_t next_s;

  // Only an installed element's channels, or the external input, may drive it.
  function automatic logic wtvs_src_ok(input logic [3:0] src, input logic [NUM_ELEM-1:0] inst);
    if (src == SRC_EXT) begin
      wtvs_src_ok = 1'b1;
    end else if (src < SRC_EXT) begin
      wtvs_src_ok = inst[src[2:1]];
    end else begin
      wtvs_src_ok = 1'b0;
    end
  endfunction

  // Applies the slope choice to a pair of edge events.
  function automatic logic wtvs_slope_hit(input wtvs_slope_t slope, input logic up,
                                          input logic down);
    case (slope)
      SLOPE_RISE: wtvs_slope_hit = up;
      SLOPE_FALL: wtvs_slope_hit = down;
      SLOPE_BOTH: wtvs_slope_hit = up | down;
      default: wtvs_slope_hit = 1'b0;
    endcase
  endfunction

  logic srcOk;
  logic isExt;
  logic usTick;
  logic signed [LEVEL_W-1:0] levelClamped;
  int levelCode;
  int hystCode;
  int cur;
  int prev;
  logic crossUp;
  logic crossDown;
  logic extUp;
  logic extDown;
  logic hit;

  // The level is given in tenths of a percent and turned into a sample code.
  // Samples arrive already scaled so that one full scale is a fixed code.
  // The external input bypasses the level entirely and is edge detected.
  // Both kinds of edge pass through the same slope choice.
  // A source that is not selectable can never produce a hit.
  // Integration also blocks every hit, whatever the sequencer state.
  // Level conversion and crossing detection.
  always_comb begin
    srcOk = wtvs_src_ok(trigCfg.source, elemInstalled);
    isExt = (trigCfg.source == SRC_EXT);
    levelClamped = trigCfg.level;
    // The level is limited to the screen span; zero sits at center.
    if (levelClamped > LEVEL_LIMIT) begin
      levelClamped = LEVEL_LIMIT;
    end else if (levelClamped < -LEVEL_LIMIT) begin
      levelClamped = -LEVEL_LIMIT;
    end
    // Samples arrive scaled so that the code for 100 % is range times crest factor.
    levelCode = int'(levelClamped) * FULL_SCALE_CODE / LEVEL_PER_FULL;
    hystCode = trigCfg.crestSix ? HYST_CF6_CODE : HYST_CF3_CODE;
    cur = int'($signed(samples.ch[trigCfg.source[2:0]]));
    prev = int'(s.prevSample);
    // A crossing needs an armed comparator and two consecutive samples.
    crossUp = !isExt && sampleValid && s.prevValid && s.armRise
      && (prev < levelCode) && (cur >= levelCode);
    crossDown = !isExt && sampleValid && s.prevValid && s.armFall
      && (prev > levelCode) && (cur <= levelCode);
    // The external input is a logic level; the level setting plays no part.
    extUp = isExt && extTrigIn && !s.extPrev;
    extDown = isExt && !extTrigIn && s.extPrev;
    hit = srcOk && !integActive
      && wtvs_slope_hit(trigCfg.slope, crossUp | extUp, crossDown | extDown);
  end

  // The microsecond tick is a one-cycle enable from the free divider.
  // Counting microseconds keeps the timeout counter narrow.
  // A full-rate counter for the default timeout would need many more bits.
  assign usTick = (s.usDiv == US_DIV_LAST);

  // Next-state logic for the comparator, timer and refresh sequencer.
  always_comb begin
    next_s = s;
    next_s.trigPulse = 1'b0;
    next_s.refresh = 1'b0;
    next_s.extPrev = extTrigIn;
    next_s.lastSource = trigCfg.source;
    next_s.sourceValid = srcOk;
    next_s.usDiv = usTick ? '0 : s.usDiv + 1'b1;

    // Apart from a source change, the arm bits are only touched by a fresh analog sample.
    // Rising re-arms strictly below the band and falling strictly above it.
    // A crossing disarms its own direction in the same cycle that it fires.
    // Noise riding on the level therefore gives one trigger, not a burst.
    // Hysteresis: re-arm only after the signal leaves the band around the level.
    if (sampleValid && !isExt) begin
      next_s.prevSample = samples.ch[trigCfg.source[2:0]];
      next_s.prevValid = 1'b1;
      if (cur < levelCode - hystCode) begin
        next_s.armRise = 1'b1;
      end
      if (cur > levelCode + hystCode) begin
        next_s.armFall = 1'b1;
      end
      if (crossUp) begin
        next_s.armRise = 1'b0;
      end
      if (crossDown) begin
        next_s.armFall = 1'b0;
      end
    end

    // A new source must not be compared against another channel's old sample.
    if (trigCfg.source != s.lastSource) begin
      next_s.prevValid = 1'b0;
      next_s.armRise = 1'b0;
      next_s.armFall = 1'b0;
    end

    // A trigger wins over a timeout that falls in the same cycle.
    // Either kind of refresh restarts the timer from zero.
    // Normal mode parks the timer, so no forced refresh can ever come.
    // Entering the free state also clears the timer for a clean restart.
    case (s.fsm)
      ST_SEEK: begin
        if (integActive) begin
          next_s.fsm = ST_FREE;
          next_s.timeoutUs = '0;
        end else if (hit) begin
          // Edge seen this clock, so the external delay is one cycle.
          next_s.trigPulse = 1'b1;
          next_s.refresh = 1'b1;
          next_s.cause = CAUSE_TRIG;
          next_s.timeoutUs = '0;
        end else if (trigCfg.mode == MODE_AUTO) begin
          if (usTick) begin
            if (s.timeoutUs == TIMEOUT_LAST) begin
              next_s.refresh = 1'b1;
              next_s.cause = CAUSE_TIMEOUT;
              next_s.timeoutUs = '0;
            end else begin
              next_s.timeoutUs = s.timeoutUs + 1'b1;
            end
          end
        end else begin
          // Normal mode waits without limit; the timer is parked.
          next_s.timeoutUs = '0;
        end
      end
      ST_FREE: begin
        // Triggering is off; every update interval refreshes unaligned.
        if (!integActive) begin
          next_s.fsm = ST_SEEK;
        end else if (updateTick) begin
          next_s.refresh = 1'b1;
          next_s.cause = CAUSE_FREE;
        end
      end
      default: begin
        next_s.fsm = ST_SEEK;
      end
    endcase
  end

  // Reset leaves the comparator unarmed, so the first crossing after reset
  // needs an arming sample first; this avoids a false trigger at start-up.
  // All state is one register; reset parks the sequencer in the seek state.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s <= '{fsm: ST_SEEK, cause: CAUSE_NONE, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // The scaler works on all eight channels in parallel.
  // It shares the sample strobe with the comparator but no other state.
  // Its output is registered inside, so it adds one cycle of latency.
  // The trigger path sees raw samples, so zoom never moves the trigger point.
  // Vertical zoom and position for every waveform.
  wtvs_vscale u_vscale (
    .ref_clk(ref_clk),
    .reset(reset),
    .samples(samples),
    .sampleValid(sampleValid),
    .vertCfg(vertCfg),
    .dispSamples(dispSamples),
    .dispValid(dispValid)
  );

  // Outputs are plain wires from the state register.
  // The pulses stand for one cycle and the cause until the next refresh.
  // A user that samples the cause late still sees the last reason.
  assign trigPulse = s.trigPulse;
  assign refresh = s.refresh;
  assign refreshCause = s.cause;
  assign sourceValid = s.sourceValid;

endmodule // wtvs_trigger

// >>> wtvs_trigger_assertions.sv
`timescale 1ns/1ps
module wtvs_trigger_assertions
  import wtvs_pkg::*;
#(
  parameter int AUTO_TIMEOUT = AUTO_TIMEOUT_US
)(
  input wire logic ref_clk,
  input wire logic reset,
  input wire wtvs_trig_cfg_t trigCfg,
  input wire logic [NUM_ELEM-1:0] elemInstalled,
  input wire wtvs_samples_t samples,
  input wire logic sampleValid,
  input wire logic extTrigIn,
  input wire logic integActive,
  input wire logic updateTick,
  input wire logic trigPulse,
  input wire logic refresh,
  input wire wtvs_cause_t refreshCause,
  input wire logic sourceValid,
  input wire logic dispValid
);
  localparam int TO_MAX = AUTO_TIMEOUT * US_TICK_CYCLES + US_TICK_CYCLES + 4;
  logic srcOk;
  logic signed [SAMPLE_W-1:0] cur;
  logic signed [SAMPLE_W-1:0] lvlCode;
  int waitCnt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Selectability of the source, the selected channel and the level as a sample code.
  assign srcOk = trigCfg.source < 4'h8 ? elemInstalled[trigCfg.source[2:1]]
                                       : trigCfg.source == SRC_EXT;
  assign cur = samples.ch[trigCfg.source[2:0]];
  assign lvlCode = {trigCfg.level[LEVEL_W-1], trigCfg.level, 4'h0};

  // Auto-mode cycles since the last refresh; the tick phase is free, so allow one tick of slack.
  always_ff @(posedge ref_clk) begin
    if (reset || refresh || integActive || trigCfg.mode != MODE_AUTO) begin
      waitCnt <= 0;
    end else begin
      waitCnt <= waitCnt + 1;
    end
  end

  sequence s_free_tick;
    integActive ##1 (integActive && updateTick);
  endsequence

  a_trig_is_refresh: assert property (trigPulse |-> refresh && refreshCause == CAUSE_TRIG)
    else $error("Trigger pulse without a trigger refresh.");
  a_rise_crossed: assert property (trigPulse && $past(trigCfg.slope) == SLOPE_RISE
      && $past(trigCfg.source) < 4'h8 |-> $past(cur) >= $past(lvlCode))
    else $error("Rising trigger below the level.");
  a_fall_crossed: assert property (trigPulse && $past(trigCfg.slope) == SLOPE_FALL
      && $past(trigCfg.source) < 4'h8 |-> $past(cur) <= $past(lvlCode))
    else $error("Falling trigger above the level.");
  a_trig_has_cause: assert property (trigPulse |-> $past(sampleValid)
      || $past(extTrigIn) != $past(extTrigIn, 2))
    else $error("Trigger without a new sample or external edge.");
  a_trig_refused: assert property (!srcOk || integActive || trigCfg.slope == 2'h3
      |=> !trigPulse)
    else $error("Trigger while triggering is not allowed.");
  a_ext_latency: assert property (trigCfg.source == SRC_EXT && trigCfg.slope == SLOPE_RISE
      && !integActive && $rose(extTrigIn) |-> ##[1:25] trigPulse)
    else $error("External edge not registered in time.");
  a_free_refresh: assert property (s_free_tick |=> refresh && refreshCause == CAUSE_FREE)
    else $error("Update tick during integration gave no free refresh.");
  a_timeout_bound: assert property (waitCnt <= TO_MAX)
    else $error("Auto mode went past the timeout without refresh.");
  a_timeout_early: assert property (refresh && refreshCause == CAUSE_TIMEOUT
      |-> waitCnt >= (AUTO_TIMEOUT - 1) * US_TICK_CYCLES)
    else $error("Timeout refresh came too early.");
  a_normal_holds: assert property (refresh && refreshCause == CAUSE_TIMEOUT
      |-> $past(trigCfg.mode) == MODE_AUTO)
    else $error("Timeout refresh in normal mode.");
  a_src_valid: assert property (!$past(reset) |-> sourceValid == $past(srcOk))
    else $error("Source valid flag wrong.");
  a_disp_valid: assert property (!$past(reset) |-> dispValid == $past(sampleValid))
    else $error("Display valid does not follow the sample strobe.");
endmodule // wtvs_trigger_assertions

bind wtvs_trigger wtvs_trigger_assertions #(.AUTO_TIMEOUT(AUTO_TIMEOUT)) i_wtvs_trigger_assertions (
  .ref_clk, .reset, .trigCfg, .elemInstalled, .samples, .sampleValid, .extTrigIn,
  .integActive, .updateTick, .trigPulse, .refresh, .refreshCause, .sourceValid, .dispValid);

// >>> wtvs_chan_model.sv
`timescale 1ns/1ps
module wtvs_chan_model
  import wtvs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic take,
  input wire logic [SAMPLE_W-1:0] value,
  input wire logic extReq,
  output wtvs_samples_t samples,
  output logic sampleValid,
  output logic extTrigIn
);
  // Quiet lines at time zero, before the first clock edge.
  initial begin
    samples = '0;
    sampleValid = 1'b0;
    extTrigIn = 1'b0;
  end

  // Between samples the channel bus carries changing junk, so only sampleValid qualifies it.
  always @(posedge ref_clk) begin
    sampleValid <= take;
    samples <= take ? {NUM_CH{value}} : ~samples;
    extTrigIn <= extReq;
  end
endmodule // wtvs_chan_model

// >>> wtvs_trigger_bench.sv
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("mismatch %s expected %h seen %h", what, exp, got); \
    end \
  end
module wtvs_trigger_bench import wtvs_pkg::*;;
  localparam int TO = 20;
  localparam logic [4:0] ZI [4] = '{5'h07, 5'h00, 5'h0f, 5'h1f};
  localparam int ZQ [4] = '{32'h100, 32'h1a, 32'h200, 32'h6400};
  logic ref_clk, reset, sampleValid, extTrigIn, integActive, updateTick, take, extReq;
  logic trigPulse, refresh, sourceValid, dispValid;
  logic [SAMPLE_W-1:0] value;
  logic [NUM_ELEM-1:0] elemInstalled;
  wtvs_trig_cfg_t trigCfg;
  wtvs_vert_cfg_t vertCfg;
  wtvs_samples_t samples, dispSamples, expDisp;
  wtvs_cause_t refreshCause, expCause;
  wtvs_cause_t causeQ[$];
  wtvs_samples_t dispQ[$];
  int bad_count = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h3;

  wtvs_trigger #(.AUTO_TIMEOUT(TO)) i_wtvs_trigger (.ref_clk, .reset, .trigCfg, .elemInstalled,
    .samples, .sampleValid, .extTrigIn, .integActive, .updateTick, .vertCfg, .trigPulse,
    .refresh, .refreshCause, .sourceValid, .dispSamples, .dispValid);
  wtvs_chan_model i_wtvs_chan_model (.ref_clk, .take, .value, .extReq, .samples, .sampleValid,
    .extTrigIn);

  // Free-running 25 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected display code: offset, zoom, arithmetic shift, then saturation to 16 bits.
  function automatic logic [15:0] scale(input int v, input int c);
    int r;
    r = v + $signed(vertCfg.position[c]) * FULL_SCALE_CODE / POS_PER_FULL;
    r = (r * ZQ[c % 4]) >>> 8;
    return 16'(r > SAMPLE_MAX ? SAMPLE_MAX : (r < SAMPLE_MIN ? SAMPLE_MIN : r));
  endfunction

  task automatic put(input int v);
    wtvs_samples_t e;
    for (int c = 0; c < NUM_CH; c++) e.ch[c] = scale(v, c);
    dispQ.push_back(e);
    value <= 16'(v);
    take <= 1'b1;
    @(posedge ref_clk);
    take <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic cfg(input wtvs_mode_t m, input int s, input logic [3:0] src, input int lvl,
                     input bit c6);
    trigCfg <= '{mode: m, slope: wtvs_slope_t'(s), source: src, level: 11'(lvl), crestSix: c6};
    repeat (2) @(posedge ref_clk);
  endtask

  // Near-miss arming, unarmed crossing, real arming, then a crossing exactly at the level.
  task automatic seq(input int d, input int lvl, input int h, input bit hit);
    int code;
    code = lvl * FULL_SCALE_CODE / LEVEL_PER_FULL;
    put(code - d * h);
    put(code + d * 5);
    put(code - d * (h + 1));
    if (hit) causeQ.push_back(CAUSE_TRIG);
    put(code);
  endtask

  task automatic finish_test();
    `CHECK("pending", 0, causeQ.size() + dispQ.size())
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Each refresh or display update takes the oldest note of its kind and compares it.
  always @(posedge ref_clk) begin
    if (refresh === 1'b1) begin
      expCause = CAUSE_NONE;
      if (causeQ.size() != 0) expCause = causeQ.pop_front();
      `CHECK("refreshCause", expCause, refreshCause)
      `CHECK("trigPulse", expCause == CAUSE_TRIG, trigPulse)
    end
    if (dispValid === 1'b1) begin
      expDisp = 'x;
      if (dispQ.size() != 0) expDisp = dispQ.pop_front();
      `CHECK("dispSamples", expDisp, dispSamples)
    end
  end

  // A hang is cut short well past the expected run of under two thousand cycles.
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    finish_test();
  end

  initial begin
    int lvl;
    reset = 1'b1;
    take = 1'b0;
    value = '0;
    extReq = 1'b0;
    integActive = 1'b0;
    updateTick = 1'b0;
    elemInstalled = 4'hf;
    trigCfg = '{MODE_NORMAL, SLOPE_RISE, 4'h0, 11'sh0, 1'b0};
    for (int c = 0; c < NUM_CH; c++) begin
      vertCfg.zoomSel[c] = ZI[c % 4];
      vertCfg.position[c] = '0;
    end
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    // Every slope, both crest factors, both directions, all eight analog sources.
    for (int s = 0; s < 3; s++) begin
      for (int k = 0; k < 4; k++) begin
        lvl = int'(rnd() % 1001) - 500;
        cfg(MODE_NORMAL, 0, SRC_EXT, lvl, k[0]);
        cfg(MODE_NORMAL, s, 4'(k + 2 * s), lvl, k[0]);
        seq(k[1] ? -1 : 1, lvl, k[0] ? HYST_CF6_CODE : HYST_CF3_CODE,
            s == 2 || s == int'(k[1]));
      end
    end
    // Uninstalled element, then an invalid source code, neither may trigger.
    elemInstalled <= 4'hb;
    for (int i = 0; i < 2; i++) begin
      cfg(MODE_NORMAL, 0, i ? 4'h9 : 4'h5, 0, 1'b0);
      `CHECK("sourceValid", 1'b0, sourceValid)
      seq(1, 0, HYST_CF3_CODE, 1'b0);
    end
    elemInstalled <= 4'hf;
    cfg(MODE_NORMAL, 0, 4'h5, 0, 1'b0);
    `CHECK("sourceValid", 1'b1, sourceValid)
    // While integrating, crossings are ignored and the update tick refreshes.
    integActive <= 1'b1;
    repeat (2) @(posedge ref_clk);
    seq(1, 0, HYST_CF3_CODE, 1'b0);
    causeQ.push_back(CAUSE_FREE);
    updateTick <= 1'b1;
    @(posedge ref_clk);
    updateTick <= 1'b0;
    integActive <= 1'b0;
    repeat (4) @(posedge ref_clk);
    // External edges with every slope; the random level must not matter.
    for (int s = 0; s < 3; s++) begin
      cfg(MODE_NORMAL, s, SRC_EXT, int'(rnd() % 1001) - 500, 1'b0);
      if (s != 1) causeQ.push_back(CAUSE_TRIG);
      extReq <= 1'b1;
      repeat (30) @(posedge ref_clk);
      if (s != 0) causeQ.push_back(CAUSE_TRIG);
      extReq <= 1'b0;
      repeat (30) @(posedge ref_clk);
    end
    // Auto mode: a trigger first, then a forced refresh; normal mode then stays quiet.
    cfg(MODE_AUTO, 0, 4'h0, 0, 1'b0);
    seq(1, 0, HYST_CF3_CODE, 1'b1);
    causeQ.push_back(CAUSE_TIMEOUT);
    repeat (700) if (causeQ.size() != 0) @(posedge ref_clk);
    cfg(MODE_NORMAL, 3, 4'h0, 0, 1'b0);
    repeat (700) @(posedge ref_clk);
    // Random positions per channel against four zoom factors, saturation included.
    for (int n = 0; n < 8; n++) begin
      for (int c = 0; c < NUM_CH; c++) begin
        vertCfg.position[c] <= 18'((int'(rnd() % 10401) - 5200) * 25);
      end
      @(posedge ref_clk);
      put(int'($signed(16'(rnd()))));
    end
    repeat (4) @(posedge ref_clk);
    finish_test();
  end
endmodule // wtvs_trigger_bench
